// >>> logic/cfg_update_pkg.sv
// Constants and types of the configuration update control block
package cfg_update_pkg;
  localparam int NREG = 12;

  typedef logic [15:0]           word_t;
  typedef logic [NREG-1:0][15:0] cfg_bank_t;

  typedef enum logic [1:0] {
    ST_STANDBY    = 2'h0,
    ST_PUMP_START = 2'h1,
    ST_ACTIVE     = 2'h3
  } drive_state_t;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS    = 6'h03;
  localparam logic [5:0] IDX_FIRST_CFG = 6'h11;
  localparam logic [5:0] IDX_LAST_CFG  = 6'h1c;

  // Slots of the configuration bank, counted from the first index
  localparam logic [3:0] SLOT_SUPPLY = 4'h0;
  localparam logic [3:0] SLOT_ADC    = 4'h1;
  localparam logic [3:0] SLOT_PWM    = 4'h2;
  localparam logic [3:0] SLOT_WD     = 4'h4;
  localparam logic [3:0] SLOT_WD2    = 4'h5;
  localparam logic [3:0] SLOT_IDRIVE = 4'h6;

  // Supply configuration fields
  localparam word_t F_GATE_SUPPLY_SETPOINT       = 16'h0003;
  localparam word_t F_SENSE_REF_CFG              = 16'h000c;
  localparam word_t F_LOGIC_SUPPLY_OVERCURRENT   = 16'h0030;
  localparam word_t F_LOGIC_SUPPLY_SOFT_START    = 16'h00c0;
  localparam word_t F_BUCK_SWITCHING_FREQUENCY   = 16'h0300;
  localparam word_t F_LOGIC_SUPPLY_TURN_ON_DELAY = 16'h0c00;
  localparam word_t F_PUMP_PRECHARGE_ENABLE      = 16'h1000;
  // Switching configuration fields
  localparam word_t F_SWITCH_INPUT_MODE    = 16'h0007;
  localparam word_t F_FREEWHEEL_CONFIG     = 16'h0008;
  localparam word_t F_BRAKE_CONFIG         = 16'h0070;
  localparam word_t F_RECIRCULATION_SELECT = 16'h0080;
  // Watchdog fields
  localparam word_t F_WATCHDOG_ALL        = 16'h1fff;
  localparam word_t F_WATCHDOG2_STANDBY   = 16'h00ff;
  localparam word_t F_ROTOR_LOCK          = 16'h0e00;
  localparam word_t F_WATCHDOG_BUCK_DISABLE = 16'h1000;

  localparam word_t SB_SUPPLY = F_GATE_SUPPLY_SETPOINT | F_SENSE_REF_CFG |
                                F_BUCK_SWITCHING_FREQUENCY |
                                F_PUMP_PRECHARGE_ENABLE;
  localparam word_t SB_PWM    = F_SWITCH_INPUT_MODE | F_RECIRCULATION_SELECT;
  localparam word_t OTP_SUPPLY = F_LOGIC_SUPPLY_SOFT_START |
                                 F_LOGIC_SUPPLY_TURN_ON_DELAY;

  // Per-slot category masks, slot 11 first
  localparam cfg_bank_t STANDBY_MASK = {{6{16'h0000}}, F_WATCHDOG2_STANDBY,
    F_WATCHDOG_ALL, 16'h0000, SB_PWM, 16'h0000, SB_SUPPLY};
  localparam cfg_bank_t OTP_MASK = {{6{16'h0000}}, F_WATCHDOG_BUCK_DISABLE,
    {4{16'h0000}}, OTP_SUPPLY};
  localparam cfg_bank_t ALIGN_MASK = {{9{16'h0000}},
    F_FREEWHEEL_CONFIG | F_BRAKE_CONFIG, {2{16'h0000}}};

  localparam word_t      CFG_RESET    = 16'h0000;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;
  localparam logic [1:0] READ_LATENCY = 2'h2;
  localparam logic [1:0] BOOT_CAPTURE = 2'h2;
  localparam logic [1:0] BOOT_DONE    = 2'h3;
endpackage

// >>> logic/cfg_mem_if.sv
// Interface between the control logic and the written-copy memory
`timescale 1ns/10ps
interface cfg_mem_if;
  import cfg_update_pkg::*;
  logic       we;
  logic [3:0] waddr;
  word_t      wdata;
  word_t      wmask;
  logic [3:0] raddr;
  word_t      rdata;
  cfg_bank_t  words;
  modport ctrl (output we, waddr, wdata, wmask, raddr,
                input rdata, words);
  modport mem  (input we, waddr, wdata, wmask, raddr,
                output rdata, words);
endinterface

// >>> logic/cfg_word_mem.sv
// Host-visible written copies of the configuration words
`timescale 1ns/10ps
module cfg_word_mem (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Access port
  cfg_mem_if.mem   port
);
  import cfg_update_pkg::*;

  typedef struct packed {
    cfg_bank_t words;
    word_t     rdata;
  } mem_state_t;

  mem_state_t s;
  mem_state_t next_s;

  always_comb begin
    next_s = s;
    if (port.we && port.waddr < 4'(NREG)) begin
      next_s.words[port.waddr] = (s.words[port.waddr] & ~port.wmask) |
                                 (port.wdata & port.wmask);
    end
    next_s.rdata = (port.raddr < 4'(NREG)) ? s.words[port.raddr] : '0;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= {{NREG{CFG_RESET}}, 16'h0000};
    end else begin
      s <= next_s;
    end
  end

  assign port.rdata = s.rdata;
  assign port.words = s.words;
endmodule

// >>> logic/config_shadow_update_control.sv
// Configuration shadow and update control with AXI4-Lite register access
//
// How it works
// R1: Writes to every configuration word are accepted at any time.
// R2: Immediate fields reach the effective copy two cycles after the write.
// R3: Freewheel and brake fields change only on a period or brake event while active.
// R4: Standby fields act only while drive enable is low.
// R5: Reads return the written value even when the effective copy lags.
// R6: Pending standby values are copied when the drive returns to standby.
// R7: Host should write standby fields before raising drive enable.
// R8: One-time fields come only from the image captured after reset.
// R9: Converter request, select and filter fields are plain immediate bits.
// R10: Supply fields split into standby, immediate and one-time categories.
// R11: Input mode and recirculation wait; freewheel and brake wait for an event.
// R12: Watchdog fields wait, rotor lock is immediate, buck disable one-time.
// R13: Gate current, timing, dead time, pump clock fields are immediate.
// R14: Drive enable low while active stops pumps, switching, to standby.
// R15: Each standby field has a written copy and a separate effective copy.
`timescale 1ns/10ps
module config_shadow_update_control (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       arst_n,
  // AXI4-Lite write address
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [7:0]                 s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  // AXI4-Lite write response
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [7:0]                 s_axi_araddr,
  // AXI4-Lite read data
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  // Device pins
  input  wire logic                       drive_enable_input,
  input  wire logic                       pump_ready,
  input  wire logic                       pwm_period_event,
  input  wire logic                       brake_event,
  input  wire logic [15:0]                otp_supply_image,
  input  wire logic [15:0]                otp_watchdog2_image,
  // Effective configuration and drive control
  output cfg_update_pkg::cfg_bank_t       effective_cfg,
  output logic                            pump_enable,
  output logic                            switch_path_enable,
  output cfg_update_pkg::drive_state_t    drive_state
);
  import cfg_update_pkg::*;

  typedef struct packed {
    logic [1:0]   den_sync;
    logic [1:0]   rdy_sync;
    logic [2:0]   pwm_sync;
    logic [2:0]   brk_sync;
    word_t        otp_a1;
    word_t        otp_a2;
    word_t        otp_b1;
    word_t        otp_b2;
    word_t        otp_supply;
    word_t        otp_wd2;
    logic [1:0]   boot_cnt;
    drive_state_t drv;
    logic         pump_en;
    logic         sw_en;
    cfg_bank_t    eff;
    logic         awready;
    logic         wready;
    logic         aw_ok;
    logic         w_ok;
    logic [7:0]   waddr;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         arready;
    logic         ar_busy;
    logic [1:0]   rd_wait;
    logic [7:0]   raddr;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;

  cfg_mem_if mem ();

  logic den_level;
  logic rdy_level;
  logic pwm_rise;
  logic brk_rise;
  logic align_ok;

  function automatic logic cfg_hit(input logic [7:0] addr);
    cfg_hit = addr[7:2] >= IDX_FIRST_CFG && addr[7:2] <= IDX_LAST_CFG;
  endfunction

  function automatic logic [3:0] cfg_slot(input logic [7:0] addr);
    cfg_slot = 4'(addr[7:2] - IDX_FIRST_CFG);
  endfunction

  cfg_word_mem u_mem (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .port    (mem.mem)
  );

  // Levels use the second synchroniser stage; event edges also use the third
  assign den_level = s.den_sync[1];
  assign rdy_level = s.rdy_sync[1];
  assign pwm_rise  = s.pwm_sync[1] & ~s.pwm_sync[2];
  assign brk_rise  = s.brk_sync[1] & ~s.brk_sync[2];
  // Aligned fields move freely outside the active state
  assign align_ok  = pwm_rise || brk_rise || s.drv != ST_ACTIVE; // see R3

  assign mem.waddr = cfg_slot(s.waddr);
  assign mem.wdata = s.wdata[15:0];
  assign mem.wmask = {{8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
  assign mem.raddr = cfg_slot(s.raddr);
  // Write is done once both address and data are held
  assign mem.we    = s.aw_ok && s.w_ok && !s.bvalid &&
                     cfg_hit(s.waddr); // see R1

  always_comb begin
    word_t upd;
    word_t otp_w;
    upd    = '0;
    otp_w  = '0;
    next_s = s;

    // Pin synchronisers
    next_s.den_sync = {s.den_sync[0], drive_enable_input};
    next_s.rdy_sync = {s.rdy_sync[0], pump_ready};
    next_s.pwm_sync = {s.pwm_sync[1:0], pwm_period_event};
    next_s.brk_sync = {s.brk_sync[1:0], brake_event};
    next_s.otp_a1   = otp_supply_image;
    next_s.otp_a2   = s.otp_a1;
    next_s.otp_b1   = otp_watchdog2_image;
    next_s.otp_b2   = s.otp_b1;

    // One-time image is taken once, shortly after reset release
    if (s.boot_cnt != BOOT_DONE) begin
      next_s.boot_cnt = s.boot_cnt + 2'h1;
    end
    if (s.boot_cnt == BOOT_CAPTURE) begin
      next_s.otp_supply = s.otp_a2; // see R8
      next_s.otp_wd2    = s.otp_b2; // see R8
    end

    // Drive state machine
    case (s.drv)
      ST_STANDBY: begin
        if (den_level) begin
          next_s.drv = ST_PUMP_START;
        end
      end
      ST_PUMP_START: begin
        if (!den_level) begin
          next_s.drv = ST_STANDBY;
        end else if (rdy_level) begin
          next_s.drv = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!den_level) begin
          next_s.drv = ST_STANDBY; // see R14
        end
      end
      default: begin
        next_s.drv = ST_STANDBY;
      end
    endcase
    next_s.pump_en = next_s.drv != ST_STANDBY; // see R14
    next_s.sw_en   = next_s.drv == ST_ACTIVE;  // see R14

    // Effective copies built per slot from the category masks
    for (int i = 0; i < NREG; i++) begin
      upd = ~STANDBY_MASK[i] & ~OTP_MASK[i]; // see R2 R9 R13
      if (!align_ok) begin
        upd = upd & ~ALIGN_MASK[i]; // see R3 R11
      end
      if (!den_level) begin
        upd = upd | STANDBY_MASK[i]; // see R4 R6 R15
      end
      if (4'(i) == SLOT_SUPPLY) begin
        otp_w = s.otp_supply; // see R10
      end else if (4'(i) == SLOT_WD2) begin
        otp_w = s.otp_wd2; // see R12
      end else begin
        otp_w = '0;
      end
      next_s.eff[i] = (mem.words[i] & upd) |
                      (s.eff[i] & ~upd & ~OTP_MASK[i]) |
                      (otp_w & OTP_MASK[i]); // see R8 R10 R12
    end

    // Write channels, taken in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_ok = 1'b1;
      next_s.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_ok  = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.aw_ok && s.w_ok && !s.bvalid) begin
      next_s.bvalid = 1'b1; // see R1
      next_s.bresp  = (cfg_hit(s.waddr) ||
                       s.waddr[7:2] == IDX_STATUS) ? RESP_OKAY : RESP_DECERR;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.aw_ok  = 1'b0;
      next_s.w_ok   = 1'b0;
    end
    next_s.awready = !next_s.aw_ok;
    next_s.wready  = !next_s.w_ok;

    // Read channel; configuration data comes from the memory register
    if (s_axi_arvalid && s.arready) begin
      next_s.ar_busy = 1'b1;
      next_s.raddr   = s_axi_araddr;
      next_s.rd_wait = READ_LATENCY;
    end
    if (s.rd_wait != 2'h0) begin
      next_s.rd_wait = s.rd_wait - 2'h1;
    end
    if (s.rd_wait == 2'h1) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      if (cfg_hit(s.raddr)) begin
        next_s.rdata = {16'h0000, mem.rdata}; // see R5
      end else if (s.raddr[7:2] == IDX_STATUS) begin
        next_s.rdata = {28'h000_0000, s.pump_en, den_level, s.drv};
      end else begin
        next_s.rdata = 32'h0000_0000;
        next_s.rresp = RESP_DECERR;
      end
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid  = 1'b0;
      next_s.ar_busy = 1'b0;
    end
    next_s.arready = !next_s.ar_busy;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready      = s.awready;
  assign s_axi_wready       = s.wready;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_arready      = s.arready;
  assign s_axi_rvalid       = s.rvalid;
  assign s_axi_rdata        = s.rdata;
  assign s_axi_rresp        = s.rresp;
  assign effective_cfg      = s.eff;
  assign pump_enable        = s.pump_en;
  assign switch_path_enable = s.sw_en;
  assign drive_state        = s.drv;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  AST_WRITE_ANY_STATE: assert property ( // see R1
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
      |-> ##2 s_axi_bvalid)
    else $error("write not answered two cycles after both handshakes");

  AST_IMMEDIATE_APPLY: assert property ( // see R2 R13
    (mem.we && mem.waddr == SLOT_IDRIVE && mem.wmask == 16'hffff)
      |-> ##2 effective_cfg[SLOT_IDRIVE] == $past(mem.wdata, 2))
    else $error("immediate field not applied after write");

  AST_ALIGNED_HOLD: assert property ( // see R3 R11
    (s.drv == ST_ACTIVE && !pwm_rise && !brk_rise) |=>
      ((effective_cfg[SLOT_PWM] ^ $past(effective_cfg[SLOT_PWM])) &
       ALIGN_MASK[SLOT_PWM]) == 16'h0000)
    else $error("aligned field changed between events");

  AST_STANDBY_FROZEN: assert property ( // see R4 R12
    den_level |=> ((effective_cfg[SLOT_WD] ^ $past(effective_cfg[SLOT_WD])) &
      F_WATCHDOG_ALL) == 16'h0000)
    else $error("standby field changed while drive enabled");

  AST_READBACK_WRITTEN: assert property ( // see R5
    ($rose(s_axi_rvalid) && cfg_hit(s.raddr))
      |-> s_axi_rdata[15:0] == $past(mem.rdata))
    else $error("readback does not show written copy");

  AST_STANDBY_LOAD: assert property ( // see R6 R15
    !den_level |=> effective_cfg[SLOT_WD] == $past(mem.words[SLOT_WD]))
    else $error("standby copy not loaded while drive enable low");

  AST_OTP_ONLY: assert property ( // see R8
    s.boot_cnt == BOOT_DONE |=>
      ((effective_cfg[SLOT_WD2] ^ s.otp_wd2) &
       F_WATCHDOG_BUCK_DISABLE) == 16'h0000)
    else $error("one-time field not taken from captured image");

  AST_CONVERTER_IMMEDIATE: assert property ( // see R9
    $changed(mem.words[SLOT_ADC]) |=>
      effective_cfg[SLOT_ADC] == $past(mem.words[SLOT_ADC]))
    else $error("converter field not applied at once");

  AST_SUPPLY_STANDBY: assert property ( // see R10
    den_level |=> ((effective_cfg[SLOT_SUPPLY] ^
      $past(effective_cfg[SLOT_SUPPLY])) & SB_SUPPLY) == 16'h0000)
    else $error("supply standby field changed while drive enabled");

  AST_DISABLE_TO_STANDBY: assert property ( // see R14
    (s.drv == ST_ACTIVE && !den_level) |=>
      (!pump_enable && !switch_path_enable && drive_state == ST_STANDBY))
    else $error("drive not stopped after enable went low");

  // Read data leaves the memory register one cycle before it is shown
  AST_READ_ANSWER: assert property ( // see R5
    (s_axi_arvalid && s_axi_arready) |-> ##3 s_axi_rvalid)
    else $error("read not answered three cycles after address");

  AST_PUMP_START: assert property ( // see R14
    (s.drv == ST_STANDBY && den_level) |=>
      (pump_enable && !switch_path_enable && drive_state == ST_PUMP_START))
    else $error("pumps not started after drive enable went high");
endmodule

// >>> testbench/host_drive_model.sv
// Host stand-in driving drive enable and timing events
`timescale 1ns/10ps
module host_drive_model #(
  parameter int PUMP_DELAY = 4
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // Requests from the test sequence
  input  wire logic enable_req,
  input  wire logic period_req,
  input  wire logic brake_req,
  // Device side
  input  wire logic pump_enable,
  output logic      drive_enable_input,
  output logic      pump_ready,
  output logic      pwm_period_event,
  output logic      brake_event
);
  int cnt;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_enable_input <= 1'b0;
      pwm_period_event   <= 1'b0;
      brake_event        <= 1'b0;
      pump_ready         <= 1'b0;
      cnt                <= 0;
    end else begin
      // Enable follows the sequence, which loads settings first
      drive_enable_input <= enable_req;
      pwm_period_event   <= period_req;
      brake_event        <= brake_req;
      // Pumps settle some cycles after being switched on
      if (!pump_enable) begin
        cnt <= 0;
      end else if (cnt < PUMP_DELAY) begin
        cnt <= cnt + 1;
      end
      pump_ready <= pump_enable && (cnt == PUMP_DELAY);
    end
  end
endmodule

// >>> testbench/tb_top.sv
// Testbench of the configuration update control block
`timescale 1ns/10ps
module tb_top;
  import cfg_update_pkg::*;
  logic         ref_clk, arst_n;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, r;
  logic         drive_enable_input, pump_ready, pwm_period_event;
  logic         brake_event, pump_enable, switch_path_enable;
  logic         enable_req, period_req, brake_req, active;
  word_t        otp_supply_image, otp_watchdog2_image, q;
  cfg_bank_t    effective_cfg;
  drive_state_t drive_state;
  word_t        wr [12], sbv [12], alv [12];
  int           err_count, tests_run, i;

  config_shadow_update_control config_shadow_update_control_inst (
    .ref_clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .drive_enable_input, .pump_ready,
    .pwm_period_event, .brake_event, .otp_supply_image,
    .otp_watchdog2_image, .effective_cfg, .pump_enable,
    .switch_path_enable, .drive_state);

  host_drive_model host_drive_model_inst (
    .ref_clk, .arst_n, .enable_req, .period_req, .brake_req,
    .pump_enable, .drive_enable_input, .pump_ready, .pwm_period_event,
    .brake_event);

  always #50 ref_clk = ~ref_clk;

  task automatic final_report;
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic chk(input word_t g, input word_t e, input string m);
    tests_run++;
    if (g !== e) fail(m);
  endtask

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    tests_run++;
    if (g !== e) fail("bus response");
  endtask

  task automatic chk_drv(input drive_state_t s, input logic p);
    tests_run++;
    if ({drive_state, pump_enable, switch_path_enable} !== {s, p, p})
      fail("drive state or outputs");
  endtask

  // One bus transfer; handshakes are seen at the negedge before the edge
  task automatic axi(input logic w, input logic [7:0] a, input word_t d);
    int  n;
    logic ha, hw, hr, hb, done;
    @(posedge ref_clk);
    if (w) begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
    end else begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
    end
    done = 1'b0;
    n = 0;
    while (!done && n < 100) begin
      @(negedge ref_clk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hr = s_axi_arvalid & s_axi_arready;
      hb = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
      r = w ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata[15:0];
      @(posedge ref_clk);
      if (ha === 1'b1) s_axi_awvalid <= 1'b0;
      if (hw === 1'b1) s_axi_wvalid <= 1'b0;
      if (hr === 1'b1) s_axi_arvalid <= 1'b0;
      if (hb === 1'b1) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
      n++;
    end
    if (!done) fail("bus hang");
  endtask

  task automatic wreg(input int s, input word_t d);
    axi(1'b1, {IDX_FIRST_CFG + 6'(s), 2'b00}, d);
    chk_resp(r, RESP_OKAY);
    wr[s] = d;
    if (!active) begin
      sbv[s] = d;
      alv[s] = d;
    end
  endtask

  task automatic rreg(input int s);
    axi(1'b0, {IDX_FIRST_CFG + 6'(s), 2'b00}, 16'h0000);
    chk_resp(r, RESP_OKAY);
    chk(q, wr[s], "readback");
  endtask

  task automatic chk_eff;
    word_t e, im;
    @(negedge ref_clk);
    for (int s = 0; s < NREG; s++) begin
      im = (s == int'(SLOT_SUPPLY)) ? otp_supply_image :
           (s == int'(SLOT_WD2)) ? otp_watchdog2_image : CFG_RESET;
      e = (wr[s] & ~(STANDBY_MASK[s] | OTP_MASK[s] | ALIGN_MASK[s])) |
          (sbv[s] & STANDBY_MASK[s]) | (alv[s] & ALIGN_MASK[s]) |
          (im & OTP_MASK[s]);
      chk(effective_cfg[s], e, "effective word");
    end
  endtask

  task automatic wait_state(input drive_state_t s);
    int n;
    n = 0;
    while (drive_state !== s && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    if (drive_state !== s) fail("drive state not reached");
  endtask

  // Brake or period event pin pulse, then aligned bits may follow
  task automatic pulse(input logic brk);
    @(posedge ref_clk);
    if (brk) brake_req <= 1'b1;
    else period_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    brake_req  <= 1'b0;
    period_req <= 1'b0;
    repeat (6) @(posedge ref_clk);
    alv = wr;
  endtask

  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    {enable_req, period_req, brake_req, active} = 4'h0;
    otp_supply_image = 16'h5a5a;
    otp_watchdog2_image = 16'h3c3c;
    err_count = 0;
    tests_run = 0;
    for (i = 0; i < NREG; i++) wr[i] = CFG_RESET;
    sbv = wr;
    alv = wr;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk_drv(ST_STANDBY, 1'b0);
    chk_eff;
    // Every slot, including one-time bits, written while in standby
    for (i = 0; i < NREG; i++) wreg(i, 16'hfff0 | 16'(i));
    repeat (2) @(posedge ref_clk);
    chk_eff;
    // Settings are in place before the drive is enabled
    @(posedge ref_clk);
    enable_req <= 1'b1;
    wait_state(ST_ACTIVE);
    active = 1'b1;
    chk_drv(ST_ACTIVE, 1'b1);
    axi(1'b0, {IDX_STATUS, 2'b00}, 16'h0000);
    chk(q, 16'h000f, "status word");
    for (i = 0; i < NREG; i++) begin
      wreg(i, {4'(i), 12'h000});
      rreg(i);
    end
    repeat (2) @(posedge ref_clk);
    chk_eff;
    pulse(1'b0);
    chk_eff;
    wreg(int'(SLOT_PWM), 16'h00ff);
    chk_eff;
    pulse(1'b1);
    chk_eff;
    @(posedge ref_clk);
    enable_req <= 1'b0;
    wait_state(ST_STANDBY);
    active = 1'b0;
    chk_drv(ST_STANDBY, 1'b0);
    repeat (3) @(posedge ref_clk);
    sbv = wr;
    alv = wr;
    chk_eff;
    axi(1'b1, 8'h40, 16'hffff);
    chk_resp(r, RESP_DECERR);
    axi(1'b0, 8'h00, 16'h0000);
    chk_resp(r, RESP_DECERR);
    chk(q, 16'h0000, "unmapped read data");
    chk_eff;
    final_report;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    final_report;
  end
endmodule
